// ---- flash_cfg_params.svh ----
`ifndef FLASH_CFG_PARAMS_SVH
`define FLASH_CFG_PARAMS_SVH
// report codes
`define CMD_WRITE_CFG 8'hb1
`define SUB_PIN 8'h01
`define SUB_MANUF 8'h02
`define SUB_PROD 8'h03
`define SUB_SERIAL 8'h04
`define DESC_TYPE_STRING 8'h03
// report byte positions
`define BYTE_CMD 7'h00
`define BYTE_SUB 7'h01
`define BYTE_LEN 7'h02
`define BYTE_TYPE 7'h03
`define PIN_BYTE_OFS 7'h02
`define STR_FIRST_BYTE 7'h04
`define REPORT_BYTES 7'h40
// string limits
`define STR_HDR_BYTES 8'h02
`define STR_MAX_LEN 8'h40
// pin settings byte fields
`define FLD_OUT_BIT 4
`define FLD_DIR_BIT 3
`define DESIG_GPIO 3'h0
`define DESIG_MAX_PIN1 3'h4
`define DESIG_MAX_OTHER 3'h3
`define PIN_BLANK_SETTING 8'h08
// register map, byte addresses
`define ADDR_REPORT_LAST 8'h3c
`define ADDR_CTRL 8'h40
`define ADDR_STATUS 8'h44
`define ADDR_PIN_STORED 8'h48
`define CTRL_EXEC_BIT 0
// result codes
`define RES_OK 8'h00
`define RES_UNSUPPORTED 8'h02
`define RES_NOT_ALLOWED 8'h03
`endif

// ---- flash_cfg_pkg.sv ----
package flash_cfg_pkg;
   typedef enum logic [3:0] {
      fn_gpio,
      fn_clock_out,
      fn_analog_input_one,
      fn_analog_input_two,
      fn_analog_input_three,
      fn_analog_output_one,
      fn_analog_output_two,
      fn_uart_tx_led,
      fn_irq_detect,
      fn_i2c_activity_led
   } pin_func_t;
   typedef enum logic {st_idle, st_copy} exec_state_t;
endpackage

// ---- pin_setup.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
module pin_setup #(
   parameter int PIN = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // stored setting
   input wire logic load,
   input wire logic [7:0] setting,
   // pin drive
   output flash_cfg_pkg::pin_func_t func_reg,
   output var logic oe_reg,
   output var logic level_reg
);
   import flash_cfg_pkg::*;

   function automatic pin_func_t decode(input logic [2:0] code);
      pin_func_t f;
      f = fn_gpio;
      case (code)
         3'h1: f = (PIN == 3) ? fn_i2c_activity_led : fn_clock_out;
         3'h2: f = (PIN == 1) ? fn_analog_input_one : (PIN == 2) ? fn_analog_input_two : fn_analog_input_three;
         3'h3: f = (PIN == 1) ? fn_uart_tx_led : (PIN == 2) ? fn_analog_output_one : fn_analog_output_two;
         3'h4: f = (PIN == 1) ? fn_irq_detect : fn_gpio;
         default: f = fn_gpio;
      endcase
      return f;
   endfunction

   logic is_gpio;
   assign is_gpio = setting[2:0] == `DESIG_GPIO;

   // designation, direction and level applied at load only
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         func_reg <= fn_gpio;
         oe_reg <= 1'b0;
         level_reg <= 1'b0;
      end else if (load) begin
         func_reg <= decode(setting[2:0]); // [RULE_02] [RULE_03] [RULE_04]
         oe_reg <= is_gpio && !setting[`FLD_DIR_BIT]; // [RULE_07]
         level_reg <= is_gpio && !setting[`FLD_DIR_BIT] && setting[`FLD_OUT_BIT]; // [RULE_05] [RULE_06]
      end
   end

   property p_gpio;
      @(posedge mclk) disable iff (!nrst)
      load && is_gpio && !setting[`FLD_DIR_BIT] |=> oe_reg && level_reg == $past(setting[`FLD_OUT_BIT]);
   endproperty
   a_gpio: assert property (p_gpio) else $error("gpio output level not applied"); // [RULE_05]

   property p_dir;
      @(posedge mclk) disable iff (!nrst)
      load && (setting[`FLD_DIR_BIT] || !is_gpio) |=> !oe_reg && !level_reg ##1 (load || !oe_reg);
   endproperty
   a_dir: assert property (p_dir) else $error("pin driven while input or alternate"); // [RULE_07]

   property p_alt;
      @(posedge mclk) disable iff (!nrst)
      load && setting[2:0] == 3'h2 |=> func_reg != fn_gpio && func_reg != fn_clock_out;
   endproperty
   a_alt: assert property (p_alt) else $error("analog input designation lost"); // [RULE_02]
endmodule
`default_nettype wire

// ---- flash_config_write_decoder.sv ----
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
// Operation
// (RULE_01) a report with the write command in byte 0 and the pin sub-command in byte 1 stores pin settings.
// (RULE_02) pin one designation picks interrupt detect, transmit led, analog input one, clock out or gpio.
// (RULE_03) pin two designation (byte 4) picks analog output one, analog input two, clock out or gpio; 1xx ignored.
// (RULE_04) pin three designation (byte 5) picks analog output two, analog input three, i2c led or gpio; 1xx ignored.
// (RULE_05) bit 4 of the pin two byte is the level driven at reset when pin two is a gpio output.
// (RULE_06) bit 4 of the pin three byte is the level driven at reset when pin three is a gpio output.
// (RULE_07) bit 3 sets direction, 1 input and 0 output, and only matters for gpio designation.
// (RULE_08) sub-command 0x02 replaces the stored manufacturer string.
// (RULE_09) sub-command 0x03 replaces the stored product string.
// (RULE_10) sub-command 0x04 replaces the stored serial-number string.
// (RULE_11) the host puts the string descriptor type 0x03 in byte 3 of every string write.
// (RULE_12) the host puts two plus twice the character count in byte 2.
// (RULE_13) character n is a 16-bit unit with low byte at 4+2n and high byte at 4+2n+1.
// (RULE_14) the character index runs from 0 to at most 30, so a string holds 31 characters at most.
// (RULE_15) written settings are kept in nonvolatile storage and only take effect at the next reset.
module flash_config_write_decoder (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // string fetch for enumeration
   input wire logic [1:0] str_sel,
   input wire logic [4:0] str_idx,
   output logic [15:0] str_char_reg,
   output logic [7:0] str_len_reg,
   // pins
   output flash_cfg_pkg::pin_func_t general_pin_one_func,
   output var logic general_pin_one_oe,
   output var logic general_pin_one_level,
   output flash_cfg_pkg::pin_func_t general_pin_two_func,
   output var logic general_pin_two_oe,
   output var logic general_pin_two_level,
   output flash_cfg_pkg::pin_func_t general_pin_three_func,
   output var logic general_pin_three_oe,
   output var logic general_pin_three_level
);
   import flash_cfg_pkg::*;

   function automatic logic [7:0] str_addr(input logic bank, input logic [1:0] sel, input logic [4:0] idx);
      return {bank, sel, idx};
   endfunction

   // report buffer
   logic [7:0] rep [0:63];
   function automatic logic [7:0] rep_byte(input logic [6:0] idx);
      return (idx < `REPORT_BYTES) ? rep[idx[5:0]] : 8'h00;
   endfunction

   // nonvolatile store, kept across reset
   logic [7:0] pin_nv [1:3] = '{default: `PIN_BLANK_SETTING};
   logic [15:0] str_mem [0:255] = '{default: 16'h0000};
   logic [7:0] len_nv [0:7] = '{default: 8'h00};
   logic [2:0] bank_nv = 3'h0;
   logic [2:0] swap_nv = 3'h0;

   exec_state_t state_reg;
   logic [1:0] sel_reg;
   logic [4:0] cnt_reg;
   logic [4:0] nchar_reg;
   logic [7:0] slen_reg;
   logic [7:0] result_reg;
   logic load_pend_reg;
   logic rd_ack_reg;

   logic busy;
   logic wr_fire;
   logic exec;
   logic is_cmd;
   logic is_pin;
   logic is_str;
   logic str_ok;
   logic [7:0] slen;
   logic [6:0] lo_idx;
   logic copy_we;
   logic copy_end;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;

   assign busy = state_reg != st_idle;
   assign avs_waitrequest = (avs_read && !rd_ack_reg) || (avs_write && (busy || load_pend_reg));
   assign wr_fire = avs_write && !avs_waitrequest;
   assign exec = wr_fire && avs_address == `ADDR_CTRL && avs_byteenable[0] && avs_writedata[`CTRL_EXEC_BIT];

   // command decode
   assign is_cmd = rep_byte(`BYTE_CMD) == `CMD_WRITE_CFG;
   assign is_pin = rep_byte(`BYTE_SUB) == `SUB_PIN; // [RULE_01]
   assign is_str = rep_byte(`BYTE_SUB) == `SUB_MANUF || rep_byte(`BYTE_SUB) == `SUB_PROD
                   || rep_byte(`BYTE_SUB) == `SUB_SERIAL; // [RULE_08] [RULE_09] [RULE_10]
   assign slen = rep_byte(`BYTE_LEN);
   // malformed headers rejected so the stored string stays intact
   assign str_ok = rep_byte(`BYTE_TYPE) == `DESC_TYPE_STRING // [RULE_11]
                   && slen >= `STR_HDR_BYTES && !slen[0] && slen <= `STR_MAX_LEN; // [RULE_12] [RULE_14]

   // copy one character per cycle
   assign lo_idx = 7'(`STR_FIRST_BYTE + {1'b0, cnt_reg, 1'b0});
   assign copy_end = state_reg == st_copy && cnt_reg == nchar_reg;
   assign copy_we = state_reg == st_copy && !copy_end;
   assign wr_addr = str_addr(!bank_nv[sel_reg], sel_reg, cnt_reg);
   assign wr_data = {rep_byte(7'(lo_idx + 7'h01)), rep_byte(lo_idx)}; // [RULE_13]

   // report buffer writes
   always_ff @(posedge mclk) begin
      if (wr_fire && avs_address <= `ADDR_REPORT_LAST) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
               rep[{avs_address[5:2], 2'(i)}] <= avs_writedata[8*i +: 8];
            end
         end
      end
   end

   // executor
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= st_idle;
         sel_reg <= 2'h0;
         cnt_reg <= 5'h00;
         nchar_reg <= 5'h00;
         slen_reg <= 8'h00;
         result_reg <= `RES_OK;
      end else begin
         case (state_reg)
            st_idle: begin
               if (exec) begin
                  if (!is_cmd || !(is_pin || is_str)) begin
                     result_reg <= `RES_UNSUPPORTED;
                  end else if (is_pin) begin
                     result_reg <= `RES_OK;
                  end else if (!str_ok) begin
                     result_reg <= `RES_NOT_ALLOWED;
                  end else begin
                     result_reg <= `RES_OK;
                     state_reg <= st_copy;
                     sel_reg <= 2'(rep_byte(`BYTE_SUB) - `SUB_MANUF); // [RULE_08] [RULE_09] [RULE_10]
                     cnt_reg <= 5'h00;
                     nchar_reg <= 5'((slen - `STR_HDR_BYTES) >> 1); // [RULE_12]
                     slen_reg <= slen;
                  end
               end
            end
            st_copy: begin
               if (copy_end) begin
                  state_reg <= st_idle;
               end else begin
                  cnt_reg <= 5'(cnt_reg + 5'h01);
               end
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // pin settings store; ignored designations keep the old one
   always_ff @(posedge mclk) begin
      if (exec && !busy && is_cmd && is_pin) begin // [RULE_15]
         for (int k = 1; k <= 3; k++) begin
            if (rep[6'(`PIN_BYTE_OFS + k)][2:0] <= ((k == 1) ? `DESIG_MAX_PIN1 : `DESIG_MAX_OTHER)) begin
               pin_nv[k] <= {3'h0, rep[6'(`PIN_BYTE_OFS + k)][4:0]}; // [RULE_02]
            end else begin
               pin_nv[k] <= {3'h0, rep[6'(`PIN_BYTE_OFS + k)][4:3], pin_nv[k][2:0]}; // [RULE_03] [RULE_04]
            end
         end
      end
   end

   // string store: writes go to the idle bank, banks swap at reset
   always_ff @(posedge mclk) begin
      if (copy_we) begin
         str_mem[wr_addr] <= wr_data; // [RULE_13]
      end
      if (copy_end) begin
         len_nv[{!bank_nv[sel_reg], sel_reg}] <= slen_reg;
         swap_nv[sel_reg] <= 1'b1; // [RULE_15]
      end
      if (load_pend_reg) begin
         bank_nv <= bank_nv ^ swap_nv; // [RULE_15]
         swap_nv <= 3'h0;
      end
   end

   // one load pulse after reset release
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         load_pend_reg <= 1'b1;
      end else begin
         load_pend_reg <= 1'b0;
      end
   end

   // enumeration fetch from the active bank
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         str_char_reg <= 16'h0000;
         str_len_reg <= 8'h00;
      end else if (str_sel == 2'h3) begin
         str_char_reg <= 16'h0000;
         str_len_reg <= 8'h00;
      end else begin
         str_char_reg <= str_mem[str_addr(bank_nv[str_sel], str_sel, str_idx)];
         str_len_reg <= len_nv[{bank_nv[str_sel], str_sel}];
      end
   end

   // register reads, one wait cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_ack_reg <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_ack_reg <= avs_read && !rd_ack_reg;
         if (avs_read && !rd_ack_reg) begin
            if (avs_address <= `ADDR_REPORT_LAST) begin
               avs_readdata <= {rep[{avs_address[5:2], 2'h3}], rep[{avs_address[5:2], 2'h2}],
                                rep[{avs_address[5:2], 2'h1}], rep[{avs_address[5:2], 2'h0}]};
            end else if (avs_address == `ADDR_STATUS) begin
               avs_readdata <= {16'h0000, result_reg, 5'h00, swap_nv != 3'h0, load_pend_reg, busy};
            end else if (avs_address == `ADDR_PIN_STORED) begin
               avs_readdata <= {8'h00, pin_nv[3], pin_nv[2], pin_nv[1]};
            end else begin
               avs_readdata <= 32'h0000_0000;
            end
         end
      end
   end

   // pin drivers
   pin_func_t func_a [1:3];
   logic oe_a [1:3];
   logic level_a [1:3];
   for (genvar g = 1; g <= 3; g++) begin : g_pin
      pin_setup #(.PIN(g)) u_pin (
         .mclk(mclk),
         .nrst(nrst),
         .load(load_pend_reg),
         .setting(pin_nv[g]),
         .func_reg(func_a[g]),
         .oe_reg(oe_a[g]),
         .level_reg(level_a[g])
      );
   end
   assign general_pin_one_func = func_a[1];
   assign general_pin_one_oe = oe_a[1];
   assign general_pin_one_level = level_a[1];
   assign general_pin_two_func = func_a[2];
   assign general_pin_two_oe = oe_a[2];
   assign general_pin_two_level = level_a[2];
   assign general_pin_three_func = func_a[3];
   assign general_pin_three_oe = oe_a[3];
   assign general_pin_three_level = level_a[3];

   property p_pin_ok;
      @(posedge mclk) disable iff (!nrst)
      exec && is_cmd && is_pin |=> result_reg == `RES_OK && state_reg == st_idle;
   endproperty
   a_pin_ok: assert property (p_pin_ok) else $error("pin write not accepted"); // [RULE_01]

   property p_ign2;
      @(posedge mclk) disable iff (!nrst)
      exec && is_cmd && is_pin && rep[4][2] |=> pin_nv[2][2:0] == $past(pin_nv[2][2:0]);
   endproperty
   a_ign2: assert property (p_ign2) else $error("pin two ignored code stored"); // [RULE_03]

   property p_ign3;
      @(posedge mclk) disable iff (!nrst)
      exec && is_cmd && is_pin && rep[5][2] |=> pin_nv[3][2:0] == $past(pin_nv[3][2:0]);
   endproperty
   a_ign3: assert property (p_ign3) else $error("pin three ignored code stored"); // [RULE_04]

   property p_hold;
      @(posedge mclk) disable iff (!nrst)
      !load_pend_reg |=> $stable(oe_a[2]) && $stable(level_a[2]) && $stable(bank_nv);
   endproperty
   a_hold: assert property (p_hold) else $error("setting applied before reset"); // [RULE_15]

   property p_str;
      @(posedge mclk) disable iff (!nrst)
      exec && is_cmd && is_str && str_ok |=> state_reg == st_copy ##[1:32] state_reg == st_idle;
   endproperty
   a_str: assert property (p_str) else $error("string write did not complete"); // [RULE_08]

   property p_sel;
      @(posedge mclk) disable iff (!nrst)
      exec && is_cmd && is_str && str_ok |=> sel_reg == 2'($past(rep[1]) - `SUB_MANUF);
   endproperty
   a_sel: assert property (p_sel) else $error("wrong string selected"); // [RULE_09]

   property p_pair;
      @(posedge mclk) disable iff (!nrst)
      copy_we && cnt_reg == 5'h00 |=> str_mem[$past(wr_addr)] == {$past(rep[5]), $past(rep[4])};
   endproperty
   a_pair: assert property (p_pair) else $error("first character misplaced"); // [RULE_13]

   property p_bad;
      @(posedge mclk) disable iff (!nrst)
      exec && is_cmd && is_str && rep[3] != `DESC_TYPE_STRING |=> result_reg == `RES_NOT_ALLOWED && !busy;
   endproperty
   a_bad: assert property (p_bad) else $error("bad descriptor type accepted"); // [RULE_11]
endmodule
`default_nettype wire

// ---- report_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
module report_host (
   // clock
   input wire logic mclk,
   // avalon-mm master
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   logic [7:0] rpt [64];
   logic timed_out;
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      timed_out = 1'b0;
   end
   // one bus transfer, held until waitrequest seen low
   task automatic cycle(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      for (n = 0; n < 200; n++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      if (n == 200) timed_out = 1'b1;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // load the report, run it, wait while busy
   task automatic execute(output logic [7:0] res);
      logic [31:0] q;
      int k;
      for (k = 0; k < 64; k += 4) begin
         cycle(1'b1, 8'(k), {rpt[k+3], rpt[k+2], rpt[k+1], rpt[k]}, q);
      end
      cycle(1'b1, `ADDR_CTRL, 32'h1, q);
      for (k = 0; k < 100; k++) begin
         cycle(1'b0, `ADDR_STATUS, 32'h0, q);
         if (q[0] === 1'b0) break;
      end
      if (k == 100) timed_out = 1'b1;
      res = q[15:8];
   endtask
   task automatic pins(input logic [7:0] p1, p2, p3, output logic [7:0] res);
      rpt = '{default: 8'h00};
      rpt[0] = `CMD_WRITE_CFG;
      rpt[1] = `SUB_PIN;
      rpt[3] = p1;
      rpt[4] = p2;
      rpt[5] = p3;
      execute(res);
   endtask
   // n is at most 31 characters, index 0 to 30
   task automatic text(input logic [7:0] sub, input int n, input logic bad_type, bad_len, output logic [7:0] res);
      int k;
      rpt = '{default: 8'h00};
      rpt[0] = `CMD_WRITE_CFG;
      rpt[1] = sub;
      rpt[2] = bad_len ? 8'h05 : 8'(2 + 2 * n);
      rpt[3] = bad_type ? 8'h04 : `DESC_TYPE_STRING;
      for (k = 4; k < 64; k++) begin
         rpt[k] = (k[0] ? 8'h80 : 8'h40) + 8'((k - 4) / 2);
      end
      execute(res);
   endtask
endmodule
`default_nettype wire

// ---- flash_config_write_decoder_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
module flash_config_write_decoder_tb_top;
   import flash_cfg_pkg::*;
   logic mclk, nrst;
   logic [7:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic [1:0] str_sel;
   logic [4:0] str_idx;
   logic [15:0] str_char_reg;
   logic [7:0] str_len_reg;
   pin_func_t f1, f2, f3;
   logic oe1, oe2, oe3, lv1, lv2, lv3;
   int miscompares, checked;
   report_host host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   flash_config_write_decoder uut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .str_sel(str_sel), .str_idx(str_idx),
      .str_char_reg(str_char_reg), .str_len_reg(str_len_reg), .general_pin_one_func(f1),
      .general_pin_one_oe(oe1), .general_pin_one_level(lv1), .general_pin_two_func(f2),
      .general_pin_two_oe(oe2), .general_pin_two_level(lv2), .general_pin_three_func(f3),
      .general_pin_three_oe(oe3), .general_pin_three_level(lv3));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      if (host.timed_out === 1'b1) begin
         miscompares++;
         wrap_up;
      end
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic result(input logic [7:0] seen, exp);
      check("result", seen, exp);
   endtask
   task automatic reset_dut;
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task automatic pins_are(input pin_func_t a, b, c, input logic [2:0] oe, lv);
      check("pin funcs", {f1, f2, f3}, {a, b, c});
      check("pin oe", {oe1, oe2, oe3}, oe);
      check("pin level", {lv1, lv2, lv3}, lv);
   endtask
   task automatic get_str(input logic [1:0] s, input logic [4:0] i, output logic [15:0] c, output logic [7:0] l);
      @(posedge mclk);
      str_sel <= s;
      str_idx <= i;
      @(posedge mclk);
      @(negedge mclk);
      c = str_char_reg;
      l = str_len_reg;
   endtask
   // every designation code of each pin with gpio levels in the first and last rows, then the stored settings
   task automatic scen_pins;
      logic [7:0] t1[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hf0};
      logic [7:0] t2[6] = '{8'h10, 8'h01, 8'h02, 8'h03, 8'h17, 8'h00};
      logic [7:0] t3[6] = '{8'h18, 8'h11, 8'h02, 8'h03, 8'h0c, 8'h10};
      pin_func_t e1[6] = '{fn_gpio, fn_clock_out, fn_analog_input_one, fn_uart_tx_led, fn_irq_detect, fn_gpio};
      pin_func_t e2[6] = '{fn_gpio, fn_clock_out, fn_analog_input_two, fn_analog_output_one,
         fn_analog_output_one, fn_gpio};
      pin_func_t e3[6] = '{fn_gpio, fn_i2c_activity_led, fn_analog_input_three, fn_analog_output_two,
         fn_analog_output_two, fn_gpio};
      logic [2:0] eo[6] = '{3'b110, 3'b000, 3'b000, 3'b000, 3'b000, 3'b111};
      logic [2:0] el[6] = '{3'b010, 3'b000, 3'b000, 3'b000, 3'b000, 3'b101};
      logic [7:0] res;
      logic [31:0] q;
      int r;
      pins_are(fn_gpio, fn_gpio, fn_gpio, 3'b000, 3'b000);
      for (r = 0; r < 6; r++) begin
         host.pins(t1[r], t2[r], t3[r], res);
         result(res, `RES_OK);
         if (r == 0) pins_are(fn_gpio, fn_gpio, fn_gpio, 3'b000, 3'b000);
         else pins_are(e1[r-1], e2[r-1], e3[r-1], eo[r-1], el[r-1]);
         reset_dut;
         pins_are(e1[r], e2[r], e3[r], eo[r], el[r]);
      end
      host.cycle(1'b0, `ADDR_PIN_STORED, 32'h0, q);
      check("pin stored", q, 32'h00100010);
   endtask
   function automatic logic [15:0] exp_char(input int i);
      return (i < 30) ? {8'h80 + 8'(i), 8'h40 + 8'(i)} : 16'h0000;
   endfunction
   // one string per family, the longest at the index limit
   task automatic scen_strings;
      int lens[3] = '{1, 30, 31};
      logic [15:0] c;
      logic [7:0] l, res;
      int s, i;
      for (s = 0; s < 3; s++) begin
         host.text(`SUB_MANUF + 8'(s), lens[s], 1'b0, 1'b0, res);
         result(res, `RES_OK);
         get_str(2'(s), 5'h00, c, l);
         check("len before reset", l, 8'h00);
      end
      reset_dut;
      for (s = 0; s < 3; s++) begin
         for (i = 0; i < lens[s]; i++) begin
            get_str(2'(s), 5'(i), c, l);
            check("char", c, exp_char(i));
         end
         check("len", l, 8'(2 + 2 * lens[s]));
      end
      get_str(2'h3, 5'h00, c, l);
      check("no string", {l, c}, 32'h0);
   endtask
   // malformed reports store nothing
   task automatic scen_refuse;
      logic [15:0] c;
      logic [7:0] l, res;
      logic [31:0] q;
      host.text(`SUB_MANUF, 5, 1'b1, 1'b0, res);
      result(res, `RES_NOT_ALLOWED);
      host.text(`SUB_PROD, 5, 1'b0, 1'b1, res);
      result(res, `RES_NOT_ALLOWED);
      host.rpt[0] = 8'hb0;
      host.execute(res);
      result(res, `RES_UNSUPPORTED);
      host.rpt[0] = `CMD_WRITE_CFG;
      host.rpt[1] = 8'h05;
      host.execute(res);
      result(res, `RES_UNSUPPORTED);
      host.cycle(1'b1, 8'h80, 32'hffffffff, q);
      host.cycle(1'b0, 8'h80, 32'h0, q);
      check("unmapped", q, 32'h0);
      reset_dut;
      get_str(2'h0, 5'h00, c, l);
      check("manuf kept", {l, c}, {8'h04, exp_char(0)});
      get_str(2'h1, 5'h00, c, l);
      check("product kept", l, 8'd62);
   endtask
   initial begin
      nrst = 1'b0;
      str_sel = 2'h3;
      str_idx = 5'h00;
      miscompares = 0;
      checked = 0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      scen_pins;
      scen_strings;
      scen_refuse;
      wrap_up;
   end
endmodule
`default_nettype wire
